// ### design/flag_host_pkg.sv
// Notes on behaviour
// - Flags active low; write zero takes, one frees
// - Select low on flag select, strobes like memory
// - Deassert select or enable between polling reads
// - Acquire by write zero, then read back
// - After failure, keep polling or withdraw with one
// - Software frees all flags from both sides
// - Memory chip enable inactive during flag access
package flag_host_pkg;
  localparam int FLAG_COUNT = 8;
  localparam int INDEX_W = 3;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 13;
  // Strobe phase lengths in ns, turned into clock counts
  localparam int CLK_NS = 40;
  localparam int SETUP_NS = 20;
  localparam int STROBE_NS = 70;
  localparam int RECOVER_NS = 20;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOVER_CYC = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 4;
  // Host command codes
  localparam logic [1:0] CMD_ACQUIRE = 2'h0;
  localparam logic [1:0] CMD_RELEASE = 2'h1;
  localparam logic [1:0] CMD_READ = 2'h2;
  localparam logic [1:0] CMD_INIT = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_STROBE, ST_RECOVER, ST_DONE
  } phase_t;
endpackage

// ### design/flag_phase_timer.sv
`timescale 1ns/1ps
module flag_phase_timer
  import flag_host_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control
  input wire logic load,
  input wire logic [CNT_W-1:0] load_value,
  output logic expired
);
  logic [CNT_W-1:0] count_reg;
  assign expired = (count_reg == '0);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= '0;
    end else if (load) begin
      count_reg <= load_value;
    end else if (!expired) begin
      count_reg <= count_reg - 4'h1;
    end
  end
endmodule // flag_phase_timer

// ### design/flag_host.sv
`timescale 1ns/1ps
module flag_host
  import flag_host_pkg::*;
#(
  parameter int FLAGS = FLAG_COUNT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Command port
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic [INDEX_W-1:0] cmd_index,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic rsp_owned,
  output logic [DATA_W-1:0] rsp_data,
  // Device pins
  output logic flag_space_select_n,
  output logic mem_chip_enable_n,
  output logic output_enable_n,
  output logic write_n,
  output logic [ADDR_W-1:0] addr,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic [DATA_W-1:0] data_in
);
  typedef enum logic [1:0] {
    OP_WRITE, OP_READ, OP_NONE
  } access_t;

  phase_t state_reg, state_next;
  logic [1:0] op_reg;
  logic [INDEX_W-1:0] index_reg;
  logic write_bit_reg;
  logic is_write_reg;
  logic side_b_reg;
  logic [INDEX_W-1:0] init_idx_reg;
  logic cmd_ready_reg, rsp_valid_reg, rsp_owned_reg;
  logic [DATA_W-1:0] rsp_data_reg;
  logic sel_n_reg, oe_n_reg, we_n_reg, doe_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] dout_reg;
  logic timer_load;
  logic [CNT_W-1:0] timer_value;
  logic timer_done;
  logic chip_off_reg;

  function automatic logic flag_taken(input logic [DATA_W-1:0] d);
    return d[0] == 1'b0;
  endfunction

  wire take = cmd_valid && cmd_ready_reg;
  // Acquire writes zero, then reads; never read first
  wire first_is_write = (cmd_op != CMD_READ);
  // Release also withdraws a refused acquire request
  wire first_bit = (cmd_op == CMD_RELEASE) || (cmd_op == CMD_INIT);
  // Init always starts from the first flag
  wire [INDEX_W-1:0] start_index = (cmd_op == CMD_INIT) ? '0 : cmd_index;
  wire acquire_pending = (op_reg == CMD_ACQUIRE) && is_write_reg;
  wire init_last = side_b_reg && (init_idx_reg == INDEX_W'(FLAGS - 1));
  wire init_more = (op_reg == CMD_INIT) && !init_last;
  wire recover_done = (state_reg == ST_RECOVER) && timer_done;
  wire finish = recover_done && !acquire_pending && !init_more;
  wire [INDEX_W-1:0] idx_step = init_idx_reg + 3'h1;
  // Last strobe cycle: output enable is still low at this edge
  wire read_capture = (state_reg == ST_STROBE) && timer_done && !is_write_reg;
  wire cmd_ready_next = !take && !finish && ((state_reg == ST_DONE) || cmd_ready_reg);

  flag_phase_timer u_timer (
    .clk(clk),
    .resetn(resetn),
    .load(timer_load),
    .load_value(timer_value),
    .expired(timer_done)
  );

  always_comb begin
    state_next = state_reg;
    timer_load = 1'b0;
    timer_value = '0;
    case (state_reg)
      ST_IDLE: begin
        if (take) begin
          state_next = ST_SETUP;
          timer_load = 1'b1;
          timer_value = CNT_W'(SETUP_CYC);
        end
      end
      ST_SETUP: begin
        if (timer_done) begin
          state_next = ST_STROBE;
          timer_load = 1'b1;
          timer_value = CNT_W'(STROBE_CYC);
        end
      end
      ST_STROBE: begin
        if (timer_done) begin
          state_next = ST_RECOVER;
          timer_load = 1'b1;
          timer_value = CNT_W'(RECOVER_CYC);
        end
      end
      ST_RECOVER: begin
        // Output enable drops here, so each poll sees fresh data
        if (timer_done) begin
          if (acquire_pending || init_more) begin
            state_next = ST_SETUP;
            timer_load = 1'b1;
            timer_value = CNT_W'(SETUP_CYC);
          end else begin
            state_next = ST_DONE;
          end
        end
      end
      ST_DONE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      op_reg <= CMD_READ;
      index_reg <= '0;
      write_bit_reg <= 1'b1;
      is_write_reg <= 1'b0;
      side_b_reg <= 1'b0;
      init_idx_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (take) begin
        op_reg <= cmd_op;
        index_reg <= start_index;
        write_bit_reg <= first_bit;
        is_write_reg <= first_is_write;
        side_b_reg <= 1'b0;
        init_idx_reg <= '0;
      end else if (recover_done) begin
        if (acquire_pending) begin
          is_write_reg <= 1'b0; // Read back ownership
        end else if (init_more) begin
          // Each flag written twice with one, both times at the same flag address
          side_b_reg <= ~side_b_reg;
          if (side_b_reg) begin
            init_idx_reg <= idx_step;
            index_reg <= idx_step;
          end
        end
      end
    end
  end

  // Pin drivers, all registered
  // Select and data stay on through recovery, so write_n always rises first
  wire next_in_access = (state_next == ST_SETUP) || (state_next == ST_STROBE) ||
    (state_next == ST_RECOVER);
  wire next_strobe = (state_next == ST_STROBE);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sel_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      doe_reg <= 1'b0;
      chip_off_reg <= 1'b1;
      addr_reg <= '0;
      dout_reg <= '0;
    end else begin
      sel_n_reg <= !next_in_access;
      oe_n_reg <= !(next_strobe && !is_write_next());
      we_n_reg <= !(next_strobe && is_write_next());
      doe_reg <= next_in_access && is_write_next();
      // Flag space only: memory array enable held off
      chip_off_reg <= 1'b1;
      addr_reg <= {{(ADDR_W-INDEX_W){1'b0}}, idx_next()};
      dout_reg <= {{(DATA_W-1){1'b0}}, bit_next()};
    end
  end

  function automatic logic is_write_next();
    return take ? first_is_write :
           (recover_done && acquire_pending) ? 1'b0 : is_write_reg;
  endfunction
  function automatic logic [INDEX_W-1:0] idx_next();
    return take ? start_index :
           (recover_done && init_more && side_b_reg) ?
           idx_step : index_reg;
  endfunction
  function automatic logic bit_next();
    return take ? first_bit : write_bit_reg;
  endfunction

  // Response capture at the end of the read strobe; no stall needed
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmd_ready_reg <= 1'b1;
      rsp_valid_reg <= 1'b0;
      rsp_owned_reg <= 1'b0;
      // Reads as a free flag, agreeing with rsp_owned low
      rsp_data_reg <= '1;
    end else begin
      cmd_ready_reg <= cmd_ready_next;
      rsp_valid_reg <= finish;
      if (read_capture) begin
        rsp_data_reg <= data_in;
        rsp_owned_reg <= flag_taken(data_in);
      end
    end
  end

  assign cmd_ready = cmd_ready_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_owned = rsp_owned_reg;
  assign rsp_data = rsp_data_reg;
  assign flag_space_select_n = sel_n_reg;
  assign mem_chip_enable_n = chip_off_reg;
  assign output_enable_n = oe_n_reg;
  assign write_n = we_n_reg;
  assign addr = addr_reg;
  assign data_out = dout_reg;
  assign data_oe = doe_reg;
endmodule // flag_host

// ### dv/flag_host_asserts.sv
`timescale 1ns/1ps
module flag_host_asserts
  import flag_host_pkg::*;
(
  // Clock, reset, command side
  input wire logic clk,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic rsp_owned,
  input wire logic [DATA_W-1:0] rsp_data,
  // Device pins
  input wire logic flag_space_select_n,
  input wire logic mem_chip_enable_n,
  input wire logic output_enable_n,
  input wire logic write_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic data_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_chip_off: assert property (mem_chip_enable_n)
    else $error("memory enable active");
  chk_addr_high: assert property (!flag_space_select_n |-> addr[ADDR_W-1:3] == '0)
    else $error("upper address bits set");
  chk_data_bits: assert property (data_oe |-> data_out[DATA_W-1:1] == '0)
    else $error("upper data bits set");
  chk_write_sel: assert property (!write_n |-> !flag_space_select_n && data_oe)
    else $error("write outside flag space");
  chk_write_hold: assert property ($rose(write_n) |-> !flag_space_select_n && data_oe)
    else $error("select or data dropped with write end");
  chk_read_sel: assert property (!output_enable_n |-> !flag_space_select_n && !data_oe)
    else $error("read without select");
  chk_idle_quiet: assert property (cmd_ready |-> flag_space_select_n && write_n)
    else $error("strobes active while idle");
  chk_owned_bit: assert property (rsp_valid |-> rsp_owned == !rsp_data[0])
    else $error("owned flag disagrees with data");
  chk_pulse_one: assert property (rsp_valid |=> !rsp_valid)
    else $error("response longer than a cycle");
  chk_answer_bound: assert property (cmd_valid && cmd_ready |-> ##[1:400] rsp_valid)
    else $error("command never answered");
  cov_write: cover property (!write_n);
  cov_read: cover property ($fell(output_enable_n));
  cov_owned: cover property (rsp_valid && rsp_owned);
endmodule // flag_host_asserts
bind flag_host flag_host_asserts flag_host_asserts_inst (.clk(clk), .resetn(resetn),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
  .rsp_owned(rsp_owned), .rsp_data(rsp_data), .flag_space_select_n(flag_space_select_n),
  .mem_chip_enable_n(mem_chip_enable_n), .output_enable_n(output_enable_n),
  .write_n(write_n), .addr(addr), .data_out(data_out), .data_oe(data_oe));

// ### dv/flag_device_model.sv
`timescale 1ns/1ps
module flag_device_model
  import flag_host_pkg::*;
(
  // Host side pins
  input wire logic sel_n,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wdata_oe,
  output logic [DATA_W-1:0] rdata
);
  // Arbitrary power-up: every flag held by the host side
  logic [FLAG_COUNT-1:0] req_l = 8'h00;
  logic [FLAG_COUNT-1:0] req_r = 8'h00;
  logic [FLAG_COUNT-1:0] own_l = 8'hFF;
  logic [FLAG_COUNT-1:0] own_r = 8'h00;
  logic [DATA_W-1:0] rd_hold = 16'h0000;
  // Left wins a tie; any fixed winner is allowed
  task automatic settle(input int i);
    if (own_l[i] && req_l[i]) own_l[i] = 1'b0;
    if (own_r[i] && req_r[i]) own_r[i] = 1'b0;
    if (!own_l[i] && !own_r[i] && !req_l[i]) own_l[i] = 1'b1;
    else if (!own_l[i] && !own_r[i] && !req_r[i]) own_r[i] = 1'b1;
  endtask
  task automatic right_write(input int i, input logic b);
    req_r[i] = b;
    settle(i);
  endtask
  always @(posedge we_n) begin
    if (!sel_n && ce_n && wdata_oe) begin
      req_l[addr[2:0]] = wdata[0];
      settle(addr[2:0]);
    end
  end
  always @(negedge oe_n or negedge sel_n) begin
    if (!sel_n && !oe_n) rd_hold = {DATA_W{~own_l[addr[2:0]]}};
  end
  // Released bus shows the inverse, so a stale value cannot pass
  assign rdata = (!sel_n && !oe_n) ? rd_hold : ~rd_hold;
endmodule // flag_device_model

// ### dv/flag_host_tb_top.sv
`timescale 1ns/1ps
module flag_host_tb_top;
  import flag_host_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_op = 2'h0;
  logic [INDEX_W-1:0] cmd_index = 3'h0;
  logic cmd_ready, rsp_valid, rsp_owned, sel_n, ce_n, oe_n, we_n, data_oe;
  logic [DATA_W-1:0] rsp_data, data_out, data_in;
  logic [ADDR_W-1:0] addr;
  int n_mismatch = 0;
  int check_count = 0;
  always #20 clk = ~clk;
  flag_host flag_host_inst (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_index(cmd_index), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_owned(rsp_owned), .rsp_data(rsp_data), .flag_space_select_n(sel_n),
    .mem_chip_enable_n(ce_n), .output_enable_n(oe_n), .write_n(we_n), .addr(addr),
    .data_out(data_out), .data_oe(data_oe), .data_in(data_in));
  flag_device_model dev (.sel_n(sel_n), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .addr(addr), .wdata(data_out), .wdata_oe(data_oe), .rdata(data_in));
  task automatic check(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask
  task automatic run(input logic [1:0] op, input logic [2:0] idx);
    int n;
    n = 0;
    @(negedge clk);
    while (cmd_ready !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    cmd_op = op;
    cmd_index = idx;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    check(n < 400, "no response");
  endtask
  task automatic t_init();
    run(CMD_INIT, 3'h0);
    for (int i = 0; i < FLAG_COUNT; i++) dev.right_write(i, 1'b1);
    for (int i = 0; i < FLAG_COUNT; i++) begin
      run(CMD_READ, i[2:0]);
      check(rsp_data === 16'hFFFF && rsp_owned === 1'b0, "flag not free");
    end
  endtask
  task automatic t_take_pass();
    run(CMD_ACQUIRE, 3'h5);
    check(rsp_owned === 1'b1 && rsp_data === 16'h0000, "acquire failed");
    check(dev.own_r[5] === 1'b0 && dev.own_l[4] === 1'b0, "wrong flag taken");
    dev.right_write(5, 1'b0);
    run(CMD_READ, 3'h5);
    check(rsp_data === 16'h0000 && dev.own_r[5] === 1'b0, "ownership lost");
    run(CMD_RELEASE, 3'h5);
    check(dev.own_r[5] === 1'b1, "pending side not given flag");
    run(CMD_READ, 3'h5);
    check(rsp_data === 16'hFFFF, "host still owns");
  endtask
  task automatic t_contend();
    run(CMD_ACQUIRE, 3'h5);
    check(rsp_owned === 1'b0 && rsp_data === 16'hFFFF, "took owned flag");
    run(CMD_RELEASE, 3'h5);
    dev.right_write(5, 1'b1);
    check(dev.own_l[5] === 1'b0 && dev.own_r[5] === 1'b0, "flag not freed");
    run(CMD_ACQUIRE, 3'h7);
    check(rsp_owned === 1'b1, "free flag refused");
  endtask
  task automatic results();
    $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #(5000 * 40);
    n_mismatch++;
    results();
  end
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    t_init();
    t_take_pass();
    t_contend();
    results();
  end
endmodule // flag_host_tb_top
